// ==== design/kmp_pkg.sv ====
package kmp_pkg;

  // ***********************************************************
  // Bus and register map
  // ***********************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int HTRANS_ACTIVE_BIT = 1;

  localparam logic [ADDR_W-1:0] A_KEY_SRC = 8'h00;
  localparam logic [ADDR_W-1:0] A_KEY_RET = 8'h04;
  localparam logic [ADDR_W-1:0] A_PE_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] A_PE_OUT = 8'h0c;
  localparam logic [ADDR_W-1:0] A_PE_PULL = 8'h10;
  localparam logic [ADDR_W-1:0] A_PE_IN = 8'h14;
  localparam logic [ADDR_W-1:0] A_IR = 8'h18;
  localparam logic [ADDR_W-1:0] A_STANDBY = 8'h1c;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] A_STACK = 8'h28;
  localparam logic [ADDR_W-1:0] A_WDT = 8'h2c;
  localparam logic [ADDR_W-1:0] A_FAULT = 8'h30;

  // ***********************************************************
  // Fields and reset values
  // ***********************************************************
  localparam int ST_W = 6;
  localparam int ST_WAKE = 0;
  localparam int ST_EXTINT = 1;
  localparam int ST_WDT = 2;
  localparam int ST_SOVF = 3;
  localparam int ST_SUDF = 4;
  localparam int ST_LOWV = 5;

  localparam int STK_PUSH = 0;
  localparam int STK_POP = 1;
  localparam int CTL_BIT = 0;
  localparam logic [2:0] STACK_LEVELS = 3'h5;

  localparam logic [7:0] KEY_SRC_RST = 8'h00;
  localparam logic [3:0] PE_RST = 4'h0;
  localparam logic [7:0] KEY_PULL_ON = 8'hff;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDT_TIME_US = 1000;
  localparam int WDT_CYCLES = WDT_TIME_US * 1000 / CLK_PERIOD_NS;

  // ***********************************************************
  // Pin carriers
  // ***********************************************************
  typedef struct packed {
    logic [3:0] key_return_group_a;
    logic [3:0] key_return_group_b;
    logic [3:0] bidir_port_e;
    logic ext_int;
    logic low_supply;
  } kmp_pin_in_t;

  typedef struct packed {
    logic [3:0] key_source_group_c_o;
    logic [3:0] key_source_group_c_oe;
    logic [3:0] key_source_group_d_o;
    logic [3:0] key_source_group_d_oe;
    logic [7:0] key_return_pullup;
    logic [3:0] bidir_port_e_o;
    logic [3:0] bidir_port_e_oe;
    logic [3:0] bidir_port_e_pullup;
    logic ir_carrier_out;
    logic osc_run;
    logic fault_out_n_o;
    logic fault_out_n_oe;
  } kmp_pin_out_t;

  localparam kmp_pin_out_t PIN_OUT_RST = '{
    key_source_group_c_o: 4'h0,
    key_source_group_c_oe: 4'hf,
    key_source_group_d_o: 4'h0,
    key_source_group_d_oe: 4'hf,
    key_return_pullup: 8'hff,
    bidir_port_e_o: 4'h0,
    bidir_port_e_oe: 4'h0,
    bidir_port_e_pullup: 4'h0,
    ir_carrier_out: 1'b0,
    osc_run: 1'b0,
    fault_out_n_o: 1'b0,
    fault_out_n_oe: 1'b0
  };

endpackage

// ==== design/kmp_sync.sv ====
`timescale 1ns/1ns
module kmp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  if (W < 1) begin : g_w_chk
    $error("kmp_sync: W must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    next_meta = ce ? d : meta;
    next_q = ce ? meta : q;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule

// ==== design/kmp_wdog.sv ====
`timescale 1ns/1ns
module kmp_wdog #(
  parameter int CYCLES = kmp_pkg::WDT_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic kick,
  output logic overflow
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_overflow;

  if (CYCLES < 2) begin : g_cycles_chk
    $error("kmp_wdog: CYCLES must be at least 2");
  end

  // Counter restarts on kick or after it wraps
  always_comb begin
    next_cnt = cnt;
    next_overflow = 1'b0;
    if (ce) begin
      if (kick) begin
        next_cnt = '0;
      end else if (cnt == LAST) begin
        next_cnt = '0;
        next_overflow = 1'b1;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end else begin
      next_overflow = overflow;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      overflow <= 1'b0;
    end else begin
      cnt <= next_cnt;
      overflow <= next_overflow;
    end
  end

endmodule

// ==== design/kmp_ports.sv ====
`timescale 1ns/1ns
module kmp_ports #(
  parameter int WDT_CYCLES = kmp_pkg::WDT_CYCLES,
  parameter bit LVD_EN = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire kmp_pkg::kmp_pin_in_t pins_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output kmp_pkg::kmp_pin_out_t pins_out
);

  if (WDT_CYCLES < 2) begin : g_wdt_chk
    $error("kmp_ports: WDT_CYCLES too small");
  end

  // ***********************************************************
  // Pin synchronisers and watchdog
  // ***********************************************************
  kmp_pkg::kmp_pin_in_t pin_s;
  logic wdt_ovf;
  logic wdt_kick;

  kmp_sync #(
    .W($bits(kmp_pkg::kmp_pin_in_t))
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .d(pins_in),
    .q(pin_s)
  );

  kmp_wdog #(
    .CYCLES(WDT_CYCLES)
  ) u_wdog (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .kick(wdt_kick),
    .overflow(wdt_ovf)
  );

  // ***********************************************************
  // AHB-Lite slave
  // ***********************************************************
  // Reads take one wait state so that a write in its data phase
  // has landed before the read word is sampled.
  logic wr_pend;
  logic rd_pend;
  logic [kmp_pkg::ADDR_W-1:0] a_addr;
  logic [31:0] rd_word;
  logic next_wr_pend;
  logic next_rd_pend;
  logic [kmp_pkg::ADDR_W-1:0] next_a_addr;
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic acc;
  logic wr;

  assign acc = hsel && htrans[kmp_pkg::HTRANS_ACTIVE_BIT] && hready;
  assign wr = wr_pend && ce;

  always_comb begin
    next_wr_pend = wr_pend;
    next_rd_pend = rd_pend;
    next_a_addr = a_addr;
    next_hrdata = hrdata;
    next_hreadyout = hreadyout;
    if (ce) begin
      next_wr_pend = 1'b0;
      next_rd_pend = 1'b0;
      next_hreadyout = 1'b1;
      if (rd_pend) begin
        next_hrdata = rd_word;
      end else if (acc) begin
        next_a_addr = haddr[kmp_pkg::ADDR_W-1:0];
        next_wr_pend = hwrite;
        next_rd_pend = !hwrite;
        next_hreadyout = hwrite;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      a_addr <= next_a_addr;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic w,
                                  input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = w && (a == target);
  endfunction

  // ***********************************************************
  // Port and control state
  // ***********************************************************
  logic [7:0] key_src;
  logic [3:0] pe_dir;
  logic [3:0] pe_out;
  logic [3:0] pe_pull;
  logic ir;
  logic standby;
  logic [kmp_pkg::ST_W-1:0] status;
  logic [kmp_pkg::ST_W-1:0] mask;
  logic [2:0] depth;
  logic fault_lat;
  logic ext_d;
  logic [7:0] next_key_src;
  logic [3:0] next_pe_dir;
  logic [3:0] next_pe_out;
  logic [3:0] next_pe_pull;
  logic next_ir;
  logic next_standby;
  logic [kmp_pkg::ST_W-1:0] next_status;
  logic [kmp_pkg::ST_W-1:0] next_mask;
  logic [2:0] next_depth;
  logic next_fault_lat;
  logic next_ext_d;
  logic key_any_low;
  logic push;
  logic pop;
  logic [kmp_pkg::ST_W-1:0] ev;
  logic [kmp_pkg::ST_W-1:0] clr;

  assign key_any_low = !(&{pin_s.key_return_group_a,
                           pin_s.key_return_group_b});
  assign push = wr_hit(wr, a_addr, kmp_pkg::A_STACK)
                && hwdata[kmp_pkg::STK_PUSH];
  assign pop = wr_hit(wr, a_addr, kmp_pkg::A_STACK)
               && hwdata[kmp_pkg::STK_POP];
  assign wdt_kick = wr_hit(wr, a_addr, kmp_pkg::A_WDT)
                    && hwdata[kmp_pkg::CTL_BIT];

  always_comb begin
    ev = '0;
    ev[kmp_pkg::ST_WAKE] = ce && standby && key_any_low;
    // Edge of the synchronised request line
    ev[kmp_pkg::ST_EXTINT] = ce && pin_s.ext_int && !ext_d;
    ev[kmp_pkg::ST_WDT] = ce && wdt_ovf;
    ev[kmp_pkg::ST_SOVF] = push && !pop
                           && depth == kmp_pkg::STACK_LEVELS;
    ev[kmp_pkg::ST_SUDF] = pop && !push && depth == 3'h0;
    ev[kmp_pkg::ST_LOWV] = ce && LVD_EN && pin_s.low_supply;
    clr = wr_hit(wr, a_addr, kmp_pkg::A_STATUS)
          ? hwdata[kmp_pkg::ST_W-1:0] : '0;
  end

  always_comb begin
    next_key_src = key_src;
    next_pe_dir = pe_dir;
    next_pe_out = pe_out;
    next_pe_pull = pe_pull;
    next_ir = ir;
    next_standby = standby;
    next_mask = mask;
    next_depth = depth;
    next_ext_d = ce ? pin_s.ext_int : ext_d;
    // A new event wins over a clear in the same cycle
    next_status = (status & ~clr) | ev;
    // Only reset clears the fault, via the wired-back pin
    next_fault_lat = fault_lat | ev[kmp_pkg::ST_WDT]
                     | ev[kmp_pkg::ST_SOVF] | ev[kmp_pkg::ST_SUDF]
                     | ev[kmp_pkg::ST_LOWV];
    if (wr) begin
      unique case (a_addr)
        kmp_pkg::A_KEY_SRC: next_key_src = hwdata[7:0];
        kmp_pkg::A_PE_DIR: next_pe_dir = hwdata[3:0];
        kmp_pkg::A_PE_OUT: next_pe_out = hwdata[3:0];
        kmp_pkg::A_PE_PULL: next_pe_pull = hwdata[3:0];
        kmp_pkg::A_IR: next_ir = hwdata[kmp_pkg::CTL_BIT];
        kmp_pkg::A_STANDBY: next_standby = hwdata[kmp_pkg::CTL_BIT];
        kmp_pkg::A_MASK: next_mask = hwdata[kmp_pkg::ST_W-1:0];
        default: begin
        end
      endcase
    end
    if (push && !pop && depth != kmp_pkg::STACK_LEVELS) begin
      next_depth = depth + 3'h1;
    end else if (pop && !push && depth != 3'h0) begin
      next_depth = depth - 3'h1;
    end
    // A pressed key always beats a request to sleep
    if (ev[kmp_pkg::ST_WAKE] || (next_standby && ce && key_any_low)) begin
      next_standby = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      key_src <= kmp_pkg::KEY_SRC_RST;
      pe_dir <= kmp_pkg::PE_RST;
      pe_out <= kmp_pkg::PE_RST;
      pe_pull <= kmp_pkg::PE_RST;
      ir <= 1'b0;
      standby <= 1'b0;
      status <= '0;
      mask <= '0;
      depth <= 3'h0;
      fault_lat <= 1'b0;
      ext_d <= 1'b0;
    end else begin
      key_src <= next_key_src;
      pe_dir <= next_pe_dir;
      pe_out <= next_pe_out;
      pe_pull <= next_pe_pull;
      ir <= next_ir;
      standby <= next_standby;
      status <= next_status;
      mask <= next_mask;
      depth <= next_depth;
      fault_lat <= next_fault_lat;
      ext_d <= next_ext_d;
    end
  end

  // ***********************************************************
  // Read data
  // ***********************************************************
  always_comb begin
    rd_word = '0;
    unique case (a_addr)
      kmp_pkg::A_KEY_SRC: rd_word[7:0] = key_src;
      kmp_pkg::A_KEY_RET: rd_word[7:0] = {pin_s.key_return_group_b,
                                          pin_s.key_return_group_a};
      kmp_pkg::A_PE_DIR: rd_word[3:0] = pe_dir;
      kmp_pkg::A_PE_OUT: rd_word[3:0] = pe_out;
      kmp_pkg::A_PE_PULL: rd_word[3:0] = pe_pull;
      kmp_pkg::A_PE_IN: rd_word[3:0] = pin_s.bidir_port_e;
      kmp_pkg::A_IR: rd_word[0] = ir;
      kmp_pkg::A_STANDBY: rd_word[0] = standby;
      kmp_pkg::A_STATUS: rd_word[kmp_pkg::ST_W-1:0] = status;
      kmp_pkg::A_MASK: rd_word[kmp_pkg::ST_W-1:0] = mask;
      kmp_pkg::A_STACK: rd_word[2:0] = depth;
      kmp_pkg::A_FAULT: rd_word[0] = fault_lat;
      default: rd_word = '0;
    endcase
  end

  // ***********************************************************
  // Registered pin drive and interrupt
  // ***********************************************************
  kmp_pkg::kmp_pin_out_t next_pins_out;
  logic next_irq;

  always_comb begin
    next_pins_out = pins_out;
    next_irq = irq;
    if (ce) begin
      next_irq = |(next_status & next_mask);
      // A zero bit pulls the key line low
      next_pins_out.key_source_group_c_oe = ~next_key_src[3:0];
      next_pins_out.key_source_group_d_oe = ~next_key_src[7:4];
      next_pins_out.key_source_group_c_o = 4'h0;
      next_pins_out.key_source_group_d_o = 4'h0;
      next_pins_out.key_return_pullup = kmp_pkg::KEY_PULL_ON;
      next_pins_out.bidir_port_e_oe = next_pe_dir;
      next_pins_out.bidir_port_e_o = next_pe_out;
      // Pull-up is meaningless while the pin drives
      next_pins_out.bidir_port_e_pullup = next_pe_pull & ~next_pe_dir;
      next_pins_out.ir_carrier_out = next_ir;
      // Oscillator off while asleep; reset holds it off too
      next_pins_out.osc_run = !next_standby;
      next_pins_out.fault_out_n_o = 1'b0;
      // Open-drain: drive low only while a fault stands
      next_pins_out.fault_out_n_oe = next_fault_lat;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pins_out <= kmp_pkg::PIN_OUT_RST;
      irq <= 1'b0;
    end else begin
      pins_out <= next_pins_out;
      irq <= next_irq;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  logic up;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      up <= 1'b0;
    end else begin
      up <= 1'b1;
    end
  end

  property p_key_pull;
    up |-> pins_out.key_return_pullup == kmp_pkg::KEY_PULL_ON;
  endproperty
  a_key_pull: assert property (p_key_pull)
    else $error("key return pull-ups not all on");

  sequence s_sleep_key;
    ce && standby && key_any_low;
  endsequence
  property p_wake;
    s_sleep_key |=> !standby && pins_out.osc_run;
  endproperty
  a_wake: assert property (p_wake)
    else $error("key press did not end standby");

  property p_key_src_boot;
    $rose(up) |-> pins_out.key_source_group_c_oe == 4'hf
                  && pins_out.key_source_group_d_oe == 4'hf;
  endproperty
  a_key_src_boot: assert property (p_key_src_boot)
    else $error("key sources not low after reset");

  property p_pe_dir;
    ce && wr_hit(wr, a_addr, kmp_pkg::A_PE_DIR)
      |=> ce [*1] |=> pins_out.bidir_port_e_oe == $past(hwdata[3:0], 2);
  endproperty
  a_pe_dir: assert property (p_pe_dir)
    else $error("port E direction not applied");

  property p_pe_pull;
    (pins_out.bidir_port_e_pullup & pins_out.bidir_port_e_oe) == 4'h0
      && ((pins_out.bidir_port_e_pullup ^ pe_pull) & ~pe_dir) == 4'h0;
  endproperty
  a_pe_pull: assert property (p_pe_pull)
    else $error("pull-up on while port E drives");

  property p_ir_boot;
    $rose(up) |-> !pins_out.ir_carrier_out;
  endproperty
  a_ir_boot: assert property (p_ir_boot)
    else $error("infrared output high after reset");

  property p_stack_ovf;
    push && !pop && depth == kmp_pkg::STACK_LEVELS
      |=> fault_lat && status[kmp_pkg::ST_SOVF]
          && pins_out.fault_out_n_oe;
  endproperty
  a_stack_ovf: assert property (p_stack_ovf)
    else $error("sixth nesting level not flagged");

  property p_fault_hold;
    fault_lat |=> fault_lat;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault cleared without reset");

  property p_wdt_fault;
    ce && wdt_ovf |=> fault_lat && status[kmp_pkg::ST_WDT];
  endproperty
  a_wdt_fault: assert property (p_wdt_fault)
    else $error("watchdog overflow not reported");

  property p_irq;
    irq == |(status & mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with status");

endmodule

// ==== verification/kmp_far_model.sv ====
`timescale 1ns/1ns
// ***********************************************************
// Key matrix, port E neighbour and fault pull-up
// ***********************************************************
module kmp_far_model (
  input wire logic core_clk,
  input wire kmp_pkg::kmp_pin_out_t po,
  input wire logic [7:0] key_press,
  input wire logic [3:0] pe_en,
  input wire logic [3:0] pe_val,
  input wire logic int_req,
  input wire logic lvd_req,
  output kmp_pkg::kmp_pin_in_t pi,
  output logic fault_n,
  output logic rst_hold_n
);
  int hold = 0;
  logic src_low;
  logic [7:0] ret;
  logic [3:0] pe_wire;
  logic [3:0] pe_last = 4'h0;
  // A key pulls its return line low only while any key source is held low
  assign src_low = |{po.key_source_group_c_oe, po.key_source_group_d_oe};
  assign ret = ~(key_press & {8{src_low}});
  // An undriven, unpulled bit floats, so it shows the inverse level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (po.bidir_port_e_oe[i]) begin
        pe_wire[i] = po.bidir_port_e_o[i];
      end else if (pe_en[i]) begin
        pe_wire[i] = pe_val[i];
      end else if (po.bidir_port_e_pullup[i]) begin
        pe_wire[i] = 1'b1;
      end else begin
        pe_wire[i] = ~pe_last[i];
      end
    end
  end
  always @(posedge core_clk) begin
    pe_last <= pe_wire;
  end
  assign pi = {ret[3:0], ret[7:4], pe_wire, int_req, lvd_req};
  // Pull-up on the fault line; released means high
  assign fault_n = po.fault_out_n_oe ? po.fault_out_n_o : 1'b1;
  // Reset circuit: a low fault pin holds reset low for four cycles,
  // although the reset it causes releases the pin at once
  always @(posedge core_clk) begin
    if (fault_n === 1'b0) hold <= 4;
    else if (hold > 0) hold <= hold - 1;
  end
  assign rst_hold_n = (hold == 0);
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
  localparam int WDT = 400;
  logic core_clk, rst_n, nrst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  kmp_pkg::kmp_pin_in_t pins_in;
  kmp_pkg::kmp_pin_out_t pins_out;
  logic [7:0] key_press;
  logic [3:0] pe_en, pe_val;
  logic int_req, lvd_req, fault_n, fault_seen, rst_hold_n, ce;
  int bad_count, checks_done;

  always #5 core_clk = ~core_clk;
  assign nrst = rst_n & rst_hold_n;
  always @(negedge fault_n) fault_seen = 1'b1;

  kmp_ports #(.WDT_CYCLES(WDT), .LVD_EN(1'b1)) kmp_ports_i (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .pins_in(pins_in),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .pins_out(pins_out));
  kmp_far_model kmp_far_model_i (
    .core_clk(core_clk), .po(pins_out), .key_press(key_press),
    .pe_en(pe_en), .pe_val(pe_val), .int_req(int_req),
    .lvd_req(lvd_req), .pi(pins_in), .fault_n(fault_n),
    .rst_hold_n(rst_hold_n));

  // ***********************************************************
  // Checking and bus tasks
  // ***********************************************************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Master waits on hready itself; no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge core_clk); n++; end
      while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge core_clk); n++; end
      while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin bad_count++; conclude(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic expect_fault(input int lim);
    int n;
    n = 0;
    while (fault_seen !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(fault_seen), 32'h1);
    fault_seen = 1'b0;
    tick(6);
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  initial begin
    int n;
    core_clk = 0; rst_n = 0; hsel = 0; htrans = 0; hwrite = 0;
    haddr = 0; hwdata = 0; hsize = 3'h2; key_press = 0; pe_en = 0;
    pe_val = 0; int_req = 0; lvd_req = 0; fault_seen = 0;
    bad_count = 0; checks_done = 0; ce = 1;
    tick(3);
    chk(32'(pins_out.osc_run), 32'h0);
    chk(32'(pins_out.ir_carrier_out), 32'h0);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(4);
    chk(32'({pins_out.key_source_group_c_oe, pins_out.key_source_group_d_oe,
      pins_out.key_return_pullup}), 32'hffff);
    chk(32'({pins_out.key_source_group_c_o,
      pins_out.key_source_group_d_o}), 32'h0);
    chk(32'({pins_out.bidir_port_e_oe, pins_out.bidir_port_e_pullup,
      pins_out.ir_carrier_out, pins_out.osc_run, pins_out.fault_out_n_oe,
      pins_out.fault_out_n_o}), 32'h4);
    rdc(kmp_pkg::A_KEY_RET, 32'hff);
    rdc(8'h3c, 32'h0);
    chk(32'(hresp), 32'h0);
    wr(kmp_pkg::A_KEY_SRC, 32'h5a);
    tick(2);
    chk(32'({pins_out.key_source_group_c_oe,
      pins_out.key_source_group_d_oe}), 32'h5a);
    rdc(kmp_pkg::A_KEY_SRC, 32'h5a);
    // Port E: bits 0 and 2 out, bits 1 and 3 held low from outside
    wr(kmp_pkg::A_PE_DIR, 32'h5);
    wr(kmp_pkg::A_PE_OUT, 32'hf);
    wr(kmp_pkg::A_PE_PULL, 32'hf);
    pe_en <= 4'ha;
    tick(4);
    chk(32'({pins_out.bidir_port_e_oe,
      pins_out.bidir_port_e_pullup}), 32'h5a);
    chk(32'(pins_out.bidir_port_e_o & 4'h5), 32'h5);
    rdc(kmp_pkg::A_PE_IN, 32'h5);
    pe_en <= 4'h0;
    tick(4);
    rdc(kmp_pkg::A_PE_IN, 32'hf);
    wr(kmp_pkg::A_IR, 32'h1);
    tick(2);
    chk(32'(pins_out.ir_carrier_out), 32'h1);
    wr(kmp_pkg::A_KEY_SRC, 32'h0);
    wr(kmp_pkg::A_STATUS, 32'h3f);
    wr(kmp_pkg::A_MASK, 32'h1);
    // One key on each return group ends standby
    for (int g = 0; g < 2; g++) begin
      wr(kmp_pkg::A_WDT, 32'h1);
      wr(kmp_pkg::A_STANDBY, 32'h1);
      tick(2);
      chk(32'(pins_out.osc_run), 32'h0);
      // Clock enable low freezes the block, so the key cannot wake it
      ce <= 1'b0;
      key_press <= 8'h01 << (5 * g);
      tick(6);
      chk(32'(pins_out.osc_run), 32'h0);
      ce <= 1'b1;
      n = 0;
      while (pins_out.osc_run !== 1'b1 && n < 20) begin
        @(posedge core_clk);
        n++;
      end
      #1;
      chk(32'(pins_out.osc_run), 32'h1);
      chk(32'(irq), 32'h1);
      key_press <= 8'h0;
      tick(4);
      wr(kmp_pkg::A_STATUS, 32'h1);
      tick(2);
      chk(32'(irq), 32'h0);
    end
    wr(kmp_pkg::A_MASK, 32'h0);
    int_req <= 1'b1;
    tick(4);
    rdc(kmp_pkg::A_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    wr(kmp_pkg::A_MASK, 32'h2);
    tick(2);
    chk(32'(irq), 32'h1);
    // Five nested calls are legal, the sixth faults and resets
    for (int k = 0; k < 5; k++) wr(kmp_pkg::A_STACK, 32'h1);
    rdc(kmp_pkg::A_STACK, 32'h5);
    chk(32'(fault_seen), 32'h0);
    wr(kmp_pkg::A_STACK, 32'h1);
    expect_fault(20);
    rdc(kmp_pkg::A_STACK, 32'h0);
    rdc(kmp_pkg::A_MASK, 32'h0);
    wr(kmp_pkg::A_STACK, 32'h2);
    expect_fault(20);
    repeat (4) begin
      wr(kmp_pkg::A_WDT, 32'h1);
      tick(WDT / 2);
    end
    chk(32'(fault_seen), 32'h0);
    expect_fault(WDT + 20);
    lvd_req <= 1'b1;
    expect_fault(20);
    lvd_req <= 1'b0;
    tick(10);
    fault_seen = 1'b0;
    tick(6);
    chk(32'(fault_seen), 32'h0);
    chk(32'(pins_out.osc_run), 32'h1);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
endmodule
